/* File: logic/arith_alu_pkg.sv */
// Purpose: Shared constants and types for the arithmetic datapath.
// Assumes: One core clock; registers on a 32-bit Avalon-MM slave.
// Notes:   Byte addresses below are word aligned.
package arith_alu_pkg;

   // Operand and result width.
   localparam int DATA_W = 8;

   // Instruction forms carried out by the datapath.
   typedef enum logic [4:0] {
      OP_ADD_WI  = 5'h00,
      OP_ADD_WM  = 5'h01,
      OP_ADD_MW  = 5'h02,
      OP_ADDC_WM = 5'h03,
      OP_ADDC_MW = 5'h04,
      OP_ADDC_W  = 5'h05,
      OP_ADDC_M  = 5'h06,
      OP_NADD_WM = 5'h07,
      OP_NADD_MW = 5'h08,
      OP_SUB_WI  = 5'h09,
      OP_SUB_WM  = 5'h0A,
      OP_SUB_MW  = 5'h0B,
      OP_SUBC_WM = 5'h0C,
      OP_SUBC_MW = 5'h0D,
      OP_SUBC_W  = 5'h0E,
      OP_SUBC_M  = 5'h0F,
      OP_INC_M   = 5'h10,
      OP_DEC_M   = 5'h11,
      OP_CLEAR_M = 5'h12
   } op_type;

   // Register byte offsets.
   localparam logic [4:0] REG_WORK_OFS   = 5'h00;
   localparam logic [4:0] REG_FLAGS_OFS  = 5'h04;
   localparam logic [4:0] REG_CTRL_OFS   = 5'h08;
   localparam logic [4:0] REG_STATUS_OFS = 5'h0C;
   localparam logic [4:0] REG_LAST_OFS   = 5'h10;

   // Flag register field positions.
   localparam int FLAG_ZERO_POS   = 0;
   localparam int FLAG_CARRY_POS  = 1;
   localparam int FLAG_NIBBLE_POS = 2;
   localparam int FLAG_SIGNED_POS = 3;
   localparam int FLAG_W          = 4;

   // Control and status field positions.
   localparam int CTRL_ENABLE_POS   = 0;
   localparam int STATUS_BADOP_POS  = 0;
   localparam int STATUS_COUNT_LSB  = 8;
   localparam int LAST_OP_LSB       = 8;

   // Reset values.
   localparam logic [7:0] WORK_RST   = 8'h00;
   localparam logic [3:0] FLAGS_RST  = 4'h0;
   localparam logic       ENABLE_RST = 1'b1;
   localparam logic [7:0] COUNT_RST  = 8'h00;

endpackage

/* File: logic/arith_instruction_alu.sv */
// Purpose: Eight-bit arithmetic datapath with working register and four status flags.
// Assumes: The decoder presents the instruction form, immediate and memory byte with op_valid.
// Notes:   One instruction per accepted cycle; results and memory writes are registered.
//
// Contract
// (RULE1) Immediate add sums working register and immediate into working register.
// (RULE2) Memory add sums working register and memory byte into chosen destination.
// (RULE3) Add with carry sums working register, memory byte and carry into destination.
// (RULE4) Working register add-carry form adds only carry to working register.
// (RULE5) Memory add-carry form adds carry to memory byte, written back there.
// (RULE6) Negate-sum into working register: memory byte minus working register.
// (RULE7) Negate-sum into memory: working register minus memory byte, written to memory.
// (RULE8) Immediate subtract: working register minus immediate into working register.
// (RULE9) Working register minus memory byte kept in working register.
// (RULE10) Memory byte minus working register written back to memory.
// (RULE11) Borrow subtract: working register minus memory minus carry into working register.
// (RULE12) Borrow subtract: memory minus working register minus carry into memory.
// (RULE13) Working register borrow form subtracts only carry from working register.
// (RULE14) Memory borrow form subtracts carry from memory byte, written back.
// (RULE15) Increment adds one to memory byte, updating all four flags.
// (RULE16) Decrement subtracts one from memory byte, updating all four flags.
// (RULE17) Clear writes zero to memory and leaves all four flags unchanged.
// (RULE18) All arithmetic forms except clear update the four flags from the result.
// (RULE19) Eight-bit operands; zero flag on zero result, signed flag on overflow.
// (RULE20) Carry is carry-out or borrow; nibble flag is bit three to four carry.
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module arith_instruction_alu #(
   parameter int AVS_ADDR_W = 5,
   parameter int WIDTH      = arith_alu_pkg::DATA_W
) (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  arst_n,
   // Instruction request from the decoder
   input  wire logic                  op_valid,
   output logic                       op_ready,
   input  wire arith_alu_pkg::op_type op_code,
   input  wire logic [7:0]            op_imm,
   input  wire logic [7:0]            op_mem,
   // Memory write-back and completion
   output logic                       mem_wr_en,
   output logic [7:0]                 mem_wr_data,
   output logic                       op_done,
   // Architectural state
   output logic [7:0]                 working_register,
   output logic                       zero_flag,
   output logic                       carry_flag,
   output logic                       nibble_wrap_bit,
   output logic                       signed_wrap_bit,
   // Avalon-MM register slave
   input  wire logic [AVS_ADDR_W-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest
);
   import arith_alu_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks.
   generate
      if (WIDTH != 8) begin : g_bad_width
         $error("arith_instruction_alu supports an eight-bit datapath only");
      end
      if (AVS_ADDR_W < 5) begin : g_bad_addr
         $error("arith_instruction_alu needs at least five address bits");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops.
   logic rst_meta_q;
   logic rst_q;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_q <= 1'b1;
         rst_q      <= 1'b1;
      end else begin
         rst_meta_q <= 1'b0;
         rst_q      <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Decoding helpers.

   // Forms whose result goes back to the addressed memory byte.
   function automatic logic dest_is_mem(input op_type op);
      case (op)
         OP_ADD_MW, OP_ADDC_MW, OP_ADDC_M, OP_NADD_MW, OP_SUB_MW,
         OP_SUBC_MW, OP_SUBC_M, OP_INC_M, OP_DEC_M, OP_CLEAR_M: dest_is_mem = 1'b1;
         default: dest_is_mem = 1'b0;
      endcase
   endfunction

   // Forms that the datapath knows; anything else is refused as a bad code.
   function automatic logic op_known(input op_type op);
      op_known = (op <= OP_CLEAR_M);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // State.
   logic [7:0] work_q;
   logic [3:0] flags_q;
   logic       enable_q;
   logic       bad_op_q;
   logic [7:0] count_q;
   logic [7:0] last_result_q;
   logic [4:0] last_op_q;
   logic       mem_wr_en_q;
   logic [7:0] mem_wr_data_q;
   logic       op_done_q;

   logic       take;
   logic       take_good;

   assign op_ready  = enable_q & ~rst_q;
   assign take      = op_valid & op_ready;
   assign take_good = take & op_known(op_code);

   ////////////////////////////////////////////////////////////////////////////////
   // Operand selection.
   logic [7:0] opnd_x;
   logic [7:0] opnd_y;
   logic       carry_in;
   logic       is_sub;
   logic       is_clear;

   always_comb begin
      opnd_x   = work_q;
      opnd_y   = 8'h00;
      carry_in = 1'b0;
      is_sub   = 1'b0;
      is_clear = 1'b0;
      case (op_code)
         OP_ADD_WI: begin
            opnd_y = op_imm; // [RULE1]
         end
         OP_ADD_WM, OP_ADD_MW: begin
            opnd_y = op_mem; // [RULE2]
         end
         OP_ADDC_WM, OP_ADDC_MW: begin
            opnd_y   = op_mem; // [RULE3]
            carry_in = flags_q[FLAG_CARRY_POS];
         end
         OP_ADDC_W: begin
            carry_in = flags_q[FLAG_CARRY_POS]; // [RULE4]
         end
         OP_ADDC_M: begin
            opnd_x   = op_mem; // [RULE5]
            carry_in = flags_q[FLAG_CARRY_POS];
         end
         OP_NADD_WM: begin
            // Negated working register plus memory equals memory minus working register.
            opnd_x = op_mem; // [RULE6]
            opnd_y = work_q;
            is_sub = 1'b1;
         end
         OP_NADD_MW: begin
            opnd_y = op_mem; // [RULE7]
            is_sub = 1'b1;
         end
         OP_SUB_WI: begin
            opnd_y = op_imm; // [RULE8]
            is_sub = 1'b1;
         end
         OP_SUB_WM: begin
            opnd_y = op_mem; // [RULE9]
            is_sub = 1'b1;
         end
         OP_SUB_MW: begin
            opnd_x = op_mem; // [RULE10]
            opnd_y = work_q;
            is_sub = 1'b1;
         end
         OP_SUBC_WM: begin
            opnd_y   = op_mem; // [RULE11]
            carry_in = flags_q[FLAG_CARRY_POS];
            is_sub   = 1'b1;
         end
         OP_SUBC_MW: begin
            opnd_x   = op_mem; // [RULE12]
            opnd_y   = work_q;
            carry_in = flags_q[FLAG_CARRY_POS];
            is_sub   = 1'b1;
         end
         OP_SUBC_W: begin
            carry_in = flags_q[FLAG_CARRY_POS]; // [RULE13]
            is_sub   = 1'b1;
         end
         OP_SUBC_M: begin
            opnd_x   = op_mem; // [RULE14]
            carry_in = flags_q[FLAG_CARRY_POS];
            is_sub   = 1'b1;
         end
         OP_INC_M: begin
            opnd_x = op_mem; // [RULE15]
            opnd_y = 8'h01;
         end
         OP_DEC_M: begin
            opnd_x = op_mem; // [RULE16]
            opnd_y = 8'h01;
            is_sub = 1'b1;
         end
         OP_CLEAR_M: begin
            is_clear = 1'b1; // [RULE17]
         end
         default: begin
            is_clear = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Adder. Subtraction adds the inverted subtrahend and inverted borrow, so one
   // carry chain serves both; the carry sense is flipped back into a borrow.
   logic [7:0] y_eff;
   logic       cin_eff;
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] result;
   logic [3:0] flags_new;

   assign y_eff   = is_sub ? ~opnd_y : opnd_y;
   assign cin_eff = is_sub ? ~carry_in : carry_in;
   assign sum9    = {1'b0, opnd_x} + {1'b0, y_eff} + {8'h00, cin_eff};
   assign sum5    = {1'b0, opnd_x[3:0]} + {1'b0, y_eff[3:0]} + {4'h0, cin_eff};
   assign result  = is_clear ? 8'h00 : sum9[7:0];

   always_comb begin
      flags_new                  = flags_q;
      flags_new[FLAG_ZERO_POS]   = (result == 8'h00); // [RULE19]
      flags_new[FLAG_CARRY_POS]  = sum9[8] ^ is_sub; // [RULE20]
      flags_new[FLAG_NIBBLE_POS] = sum5[4] ^ is_sub; // [RULE20]
      flags_new[FLAG_SIGNED_POS] = (opnd_x[7] == y_eff[7]) && (result[7] != opnd_x[7]); // [RULE19]
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave. Every access waits one cycle so read data are registered.
   logic        req;
   logic        ack_q;
   logic        wr_go;
   logic [31:0] rdata_q;
   logic [4:0]  reg_ofs;
   logic        hit_hi_zero;

   // Address bits above the register window must be zero for a register hit.
   assign hit_hi_zero     = ((avs_address >> 5) == '0);
   assign req             = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_q;
   assign wr_go           = avs_write & ack_q & avs_byteenable[0];
   assign reg_ofs         = avs_address[4:0];

   always_ff @(posedge mclk or posedge rst_q) begin
      if (rst_q) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   always_ff @(posedge mclk or posedge rst_q) begin
      if (rst_q) begin
         rdata_q <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         if (!hit_hi_zero) begin
            rdata_q <= 32'h0000_0000;
         end else if (reg_ofs == REG_WORK_OFS) begin
            rdata_q <= {24'h000000, work_q};
         end else if (reg_ofs == REG_FLAGS_OFS) begin
            rdata_q <= {28'h0000000, flags_q};
         end else if (reg_ofs == REG_CTRL_OFS) begin
            rdata_q <= {31'h00000000, enable_q};
         end else if (reg_ofs == REG_STATUS_OFS) begin
            rdata_q <= {16'h0000, count_q, 7'h00, bad_op_q};
         end else if (reg_ofs == REG_LAST_OFS) begin
            rdata_q <= {19'h00000, last_op_q, last_result_q};
         end else begin
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   assign avs_readdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Working register. An instruction in the same cycle beats a software write.
   always_ff @(posedge mclk or posedge rst_q) begin
      if (rst_q) begin
         work_q <= WORK_RST;
      end else if (take_good && !dest_is_mem(op_code)) begin
         work_q <= result; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE6] [RULE8] [RULE9] [RULE11] [RULE13]
      end else if (wr_go && hit_hi_zero && reg_ofs == REG_WORK_OFS) begin
         work_q <= avs_writedata[7:0];
      end
   end

   // Status flags. Clear keeps them; every other known form loads them.
   always_ff @(posedge mclk or posedge rst_q) begin
      if (rst_q) begin
         flags_q <= FLAGS_RST;
      end else if (take_good && !is_clear) begin
         flags_q <= flags_new; // [RULE18]
      end else if (wr_go && hit_hi_zero && reg_ofs == REG_FLAGS_OFS) begin
         flags_q <= avs_writedata[3:0];
      end
   end

   // Enable gates the request handshake so software can freeze the datapath.
   always_ff @(posedge mclk or posedge rst_q) begin
      if (rst_q) begin
         enable_q <= ENABLE_RST;
      end else if (wr_go && hit_hi_zero && reg_ofs == REG_CTRL_OFS) begin
         enable_q <= avs_writedata[CTRL_ENABLE_POS];
      end
   end

   // Bad-code flag is sticky; writing one clears it, but a new bad code wins.
   always_ff @(posedge mclk or posedge rst_q) begin
      if (rst_q) begin
         bad_op_q <= 1'b0;
      end else if (take && !op_known(op_code)) begin
         bad_op_q <= 1'b1;
      end else if (wr_go && hit_hi_zero && reg_ofs == REG_STATUS_OFS
                   && avs_writedata[STATUS_BADOP_POS]) begin
         bad_op_q <= 1'b0;
      end
   end

   // Executed-instruction count wraps at 256.
   always_ff @(posedge mclk or posedge rst_q) begin
      if (rst_q) begin
         count_q <= COUNT_RST;
      end else if (take_good) begin
         count_q <= count_q + 8'h01;
      end
   end

   always_ff @(posedge mclk or posedge rst_q) begin
      if (rst_q) begin
         last_result_q <= 8'h00;
         last_op_q     <= 5'h00;
      end else if (take_good) begin
         last_result_q <= result;
         last_op_q     <= op_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Memory write-back, one cycle after the instruction is taken.
   always_ff @(posedge mclk or posedge rst_q) begin
      if (rst_q) begin
         mem_wr_en_q   <= 1'b0;
         mem_wr_data_q <= 8'h00;
         op_done_q     <= 1'b0;
      end else begin
         mem_wr_en_q <= take_good && dest_is_mem(op_code); // [RULE2] [RULE5] [RULE7] [RULE10]
         op_done_q   <= take_good;
         if (take_good && dest_is_mem(op_code)) begin
            mem_wr_data_q <= result; // [RULE12] [RULE14] [RULE15] [RULE16] [RULE17]
         end
      end
   end

   assign mem_wr_en        = mem_wr_en_q;
   assign mem_wr_data      = mem_wr_data_q;
   assign op_done          = op_done_q;
   assign working_register = work_q;
   assign zero_flag        = flags_q[FLAG_ZERO_POS];
   assign carry_flag       = flags_q[FLAG_CARRY_POS];
   assign nibble_wrap_bit  = flags_q[FLAG_NIBBLE_POS];
   assign signed_wrap_bit  = flags_q[FLAG_SIGNED_POS];

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst_q);

   sequence s_take(op_type o);
      op_valid && op_ready && op_code == o;
   endsequence

   sequence s_mem_done;
      mem_wr_en && op_done;
   endsequence

   AST_ADD_IMM: assert property (s_take(OP_ADD_WI) |=> // [RULE1]
      working_register == 8'($past(working_register) + $past(op_imm)))
      else $error("immediate add result wrong");

   AST_ADDC_MEM_DEST: assert property (s_take(OP_ADDC_MW) |=> s_mem_done ##0 // [RULE3]
      mem_wr_data == 8'($past(working_register) + $past(op_mem) + {7'h00, $past(carry_flag)}))
      else $error("add with carry to memory wrong");

   AST_ADDC_W: assert property (s_take(OP_ADDC_W) |=> // [RULE4]
      working_register == 8'($past(working_register) + {7'h00, $past(carry_flag)}))
      else $error("carry-only add wrong");

   AST_NADD_MEM: assert property (s_take(OP_NADD_MW) |=> s_mem_done ##0 // [RULE7]
      mem_wr_data == 8'($past(working_register) - $past(op_mem))
      ##1 (mem_wr_en == $past(take_good && dest_is_mem(op_code))))
      else $error("negate-sum to memory wrong or write not one cycle");

   AST_SUB_BORROW: assert property (s_take(OP_SUB_WI) |=> // [RULE20]
      carry_flag == ($past(working_register) < $past(op_imm)))
      else $error("subtract borrow wrong");

   AST_SUBC_W: assert property (s_take(OP_SUBC_W) |=> // [RULE13]
      working_register == 8'($past(working_register) - {7'h00, $past(carry_flag)}))
      else $error("carry-only subtract wrong");

   AST_INC: assert property (s_take(OP_INC_M) |=> s_mem_done ##0 // [RULE15]
      mem_wr_data == 8'($past(op_mem) + 8'h01) && zero_flag == ($past(op_mem) == 8'hFF))
      else $error("increment wrong");

   AST_DEC: assert property (s_take(OP_DEC_M) |=> s_mem_done ##0 // [RULE16]
      carry_flag == ($past(op_mem) == 8'h00) && mem_wr_data == 8'($past(op_mem) - 8'h01))
      else $error("decrement wrong");

   AST_CLEAR_KEEP: assert property (s_take(OP_CLEAR_M) |=> s_mem_done ##0 // [RULE17]
      mem_wr_data == 8'h00 && $stable(zero_flag) && $stable(carry_flag)
      && $stable(nibble_wrap_bit) && $stable(signed_wrap_bit))
      else $error("clear wrong or flags moved");

   AST_ZERO_FLAG: assert property (op_done && !$past(is_clear) |-> // [RULE19]
      zero_flag == (last_result_q == 8'h00))
      else $error("zero flag does not match result");

   AST_WORK_HOLD: assert property (take_good && dest_is_mem(op_code) && !wr_go |=> // [RULE2]
      $stable(working_register))
      else $error("memory-destination form changed working register");

endmodule

/* File: test/mem_model.sv */
// Purpose: Decoder and data-memory stand-in that feeds instructions to the datapath.
// Assumes: One memory byte is addressed per instruction; the caller enters tasks on an edge.
// Notes:   Released operand lines show the inverse of their last value, never a stale copy.
`timescale 1ns/1ps
module mem_model (
   // Clock
   input  wire logic                   mclk,
   // Handshake with the datapath
   input  wire logic                   op_ready,
   output logic                        op_valid,
   output arith_alu_pkg::op_type       op_code,
   output logic [7:0]                  op_imm,
   output logic [7:0]                  op_mem,
   // Memory write-back
   input  wire logic                   mem_wr_en,
   input  wire logic [7:0]             mem_wr_data
);
   import arith_alu_pkg::*;

   logic [7:0] mem_byte;

   initial begin
      op_valid = 1'b0;
      op_code  = OP_ADD_WI;
      op_imm   = 8'h00;
      op_mem   = 8'h00;
      mem_byte = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Holding the request until it is taken keeps a slow ready from losing an op.
   task automatic issue(input op_type op, input logic [7:0] imm, input logic last);
      op_valid <= 1'b1;
      op_code  <= op;
      op_imm   <= imm;
      op_mem   <= mem_byte;
      do @(posedge mclk); while (op_ready !== 1'b1);
      if (last) begin
         op_valid <= 1'b0;
         op_mem   <= ~mem_byte;
         op_imm   <= ~imm;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      if (mem_wr_en === 1'b1) begin
         mem_byte <= mem_wr_data;
      end
   end
endmodule

/* File: test/tb_arith_instruction_alu.sv */
// Purpose: Self-checking bench for the arithmetic datapath and its register slave.
// Assumes: Expected results come from an independent byte adder model below.
// Notes:   Subtraction is modelled as an add of the inverted operand with inverted carry.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_arith_instruction_alu;
   import arith_alu_pkg::*;

   logic mclk, arst_n, op_valid, op_ready, mem_wr_en, op_done;
   logic zero_flag, carry_flag, nibble_wrap_bit, signed_wrap_bit;
   logic avs_read, avs_write, avs_waitrequest;
   logic [7:0] op_imm, op_mem, mem_wr_data, working_register;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable;
   op_type op_code;
   int n_errors, n_tests;
   logic [7:0] vw[3] = '{8'h7F, 8'h80, 8'h00};
   logic [7:0] vm[3] = '{8'h01, 8'hFF, 8'h00};
   logic [7:0] vi[3] = '{8'h0F, 8'h80, 8'h00};
   logic vc[3] = '{1'b1, 1'b0, 1'b1};

   arith_instruction_alu arith_instruction_alu_inst (.mclk(mclk), .arst_n(arst_n),
      .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_imm(op_imm),
      .op_mem(op_mem), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data), .op_done(op_done),
      .working_register(working_register), .zero_flag(zero_flag), .carry_flag(carry_flag),
      .nibble_wrap_bit(nibble_wrap_bit), .signed_wrap_bit(signed_wrap_bit),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   mem_model mem_model_inst (.mclk(mclk), .op_ready(op_ready), .op_valid(op_valid),
      .op_code(op_code), .op_imm(op_imm), .op_mem(op_mem), .mem_wr_en(mem_wr_en),
      .mem_wr_data(mem_wr_data));

   always #25 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////////////
   // Returns {memory destination, result, carry, nibble, signed}.
   function automatic logic [11:0] model(op_type op, logic [7:0] w, m, i, logic c);
      logic [7:0] a, b, bb;
      logic sb, ci, dm;
      logic [8:0] s;
      logic [4:0] n;
      case (op)
         OP_ADD_WI:  {a, b, sb, ci, dm} = {w, i, 3'b000};
         OP_ADD_WM:  {a, b, sb, ci, dm} = {w, m, 3'b000};
         OP_ADD_MW:  {a, b, sb, ci, dm} = {w, m, 3'b001};
         OP_ADDC_WM: {a, b, sb, ci, dm} = {w, m, 1'b0, c, 1'b0};
         OP_ADDC_MW: {a, b, sb, ci, dm} = {w, m, 1'b0, c, 1'b1};
         OP_ADDC_W:  {a, b, sb, ci, dm} = {w, 8'h00, 1'b0, c, 1'b0};
         OP_ADDC_M:  {a, b, sb, ci, dm} = {m, 8'h00, 1'b0, c, 1'b1};
         OP_NADD_WM: {a, b, sb, ci, dm} = {m, w, 3'b100};
         OP_NADD_MW: {a, b, sb, ci, dm} = {w, m, 3'b101};
         OP_SUB_WI:  {a, b, sb, ci, dm} = {w, i, 3'b100};
         OP_SUB_WM:  {a, b, sb, ci, dm} = {w, m, 3'b100};
         OP_SUB_MW:  {a, b, sb, ci, dm} = {m, w, 3'b101};
         OP_SUBC_WM: {a, b, sb, ci, dm} = {w, m, 1'b1, c, 1'b0};
         OP_SUBC_MW: {a, b, sb, ci, dm} = {m, w, 1'b1, c, 1'b1};
         OP_SUBC_W:  {a, b, sb, ci, dm} = {w, 8'h00, 1'b1, c, 1'b0};
         OP_SUBC_M:  {a, b, sb, ci, dm} = {m, 8'h00, 1'b1, c, 1'b1};
         OP_INC_M:   {a, b, sb, ci, dm} = {m, 8'h01, 3'b001};
         default:    {a, b, sb, ci, dm} = {m, 8'h01, 3'b101};
      endcase
      bb = sb ? ~b : b;
      ci = ci ^ sb;
      s = a + bb + ci;
      n = a[3:0] + bb[3:0] + ci;
      return {dm, s[7:0], s[8] ^ sb, n[4] ^ sb, (a[7] == bb[7]) && (s[7] != a[7])};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus tasks enter and leave on a rising edge, with one idle edge after release.
   task automatic avs_wr(input logic [4:0] a, input logic [7:0] d);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= 4'hF;
      avs_write <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic avs_rd(input logic [4:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic run(input op_type op, input logic [7:0] w, m, i, input logic c);
      logic [11:0] e;
      logic [7:0] r;
      e = model(op, w, m, i, c);
      r = e[10:3];
      avs_wr(REG_WORK_OFS, w);
      avs_wr(REG_FLAGS_OFS, {6'h00, c, 1'b0});
      mem_model_inst.mem_byte = m;
      mem_model_inst.issue(op, i, 1'b1);
      #1;
      `CHK("op_done", 1'b1, op_done)
      `CHK("mem_wr_en", e[11], mem_wr_en)
      if (e[11]) `CHK("mem_wr_data", r, mem_wr_data)
      `CHK("work", e[11] ? w : r, working_register)
      `CHK("flags", {e[0], e[1], e[2], r == 8'h00}, {signed_wrap_bit, nibble_wrap_bit,
         carry_flag, zero_flag})
      @(posedge mclk);
   endtask

   task automatic wrap_up();
      if (n_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      wrap_up();
   end

   initial begin
      {mclk, arst_n, avs_read, avs_write} = 4'h0;
      {avs_address, avs_writedata, avs_byteenable} = '0;
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      // Boundary operands: signed wrap, carry out, borrow and zero results.
      for (int k = 0; k < 3; k++)
         for (int o = 0; o <= 17; o++)
            run(op_type'(o), vw[k], vm[k], vi[k], vc[k]);
      // Back to back: the carry-only form must see the carry of the op before it.
      avs_wr(REG_WORK_OFS, 8'hFF);
      avs_wr(REG_FLAGS_OFS, 8'h00);
      mem_model_inst.issue(OP_ADD_WI, 8'h01, 1'b0);
      mem_model_inst.issue(OP_ADDC_W, 8'h00, 1'b1);
      #1;
      `CHK("work", 8'h01, working_register)
      `CHK("carry", 1'b0, carry_flag)
      @(posedge mclk);
      // Clear writes zero and leaves every flag as it was.
      avs_wr(REG_WORK_OFS, 8'h3C);
      avs_wr(REG_FLAGS_OFS, 8'h0F);
      mem_model_inst.mem_byte = 8'h5A;
      mem_model_inst.issue(OP_CLEAR_M, 8'h00, 1'b1);
      #1;
      `CHK("mem_wr_en", 1'b1, mem_wr_en)
      `CHK("mem_wr_data", 8'h00, mem_wr_data)
      `CHK("flags", 4'hF, {signed_wrap_bit, nibble_wrap_bit, carry_flag, zero_flag})
      `CHK("work", 8'h3C, working_register)
      @(posedge mclk);
      avs_rd(REG_FLAGS_OFS, rd);
      `CHK("flags_reg", 32'h0000000F, rd)
      // Disabled core refuses instructions; unmapped offsets read zero.
      avs_wr(REG_CTRL_OFS, 8'h00);
      #1;
      `CHK("op_ready", 1'b0, op_ready)
      @(posedge mclk);
      avs_wr(5'h14, 8'hAA);
      avs_rd(5'h14, rd);
      `CHK("unmapped", 32'h00000000, rd)
      avs_wr(REG_CTRL_OFS, 8'h01);
      run(OP_INC_M, 8'h00, 8'h0F, 8'h00, 1'b0);
      // Fifty-eight known instructions were executed and none was refused.
      avs_rd(REG_STATUS_OFS, rd);
      `CHK("status", 32'h00003A00, rd)
      avs_rd(REG_LAST_OFS, rd);
      `CHK("last", 32'h00001010, rd)
      wrap_up();
   end
endmodule
